/* hw/fmrs_pkg.sv */
// constants shared by the fault monitor and reset sequencer
// assumes a 100 MHz ref_clk and an APB master with 32-bit data
`default_nettype none

package fmrs_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNTH_LOCK_NS = 2_000_000;
  localparam int SYNTH_LOCK_CYCLES = (SYNTH_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_FRAMES = 1041;
  localparam int CLK_LOSS_CYCLES = 20000;

  // ****************************************
  // register indices (byte address is four times the index)
  // ****************************************
  localparam logic [5:0] IDX_GEN1 = 6'h00;
  localparam logic [5:0] IDX_GEN2 = 6'h01;
  localparam logic [5:0] IDX_MODE = 6'h02;
  localparam logic [5:0] IDX_SUMMARY = 6'h07;
  localparam logic [5:0] IDX_MON1 = 6'h08;
  localparam logic [5:0] IDX_MON4 = 6'h0b;
  localparam logic [5:0] IDX_MASK1 = 6'h0c;
  localparam logic [5:0] IDX_MASK4 = 6'h0f;
  localparam logic [5:0] IDX_INTSET = 6'h14;
  localparam logic [5:0] IDX_THB_HI = 6'h18;
  localparam logic [5:0] IDX_THB_LO = 6'h19;
  localparam logic [5:0] IDX_THC_HI = 6'h1a;
  localparam logic [5:0] IDX_THC_LO = 6'h1b;
  localparam logic [5:0] IDX_DIAG = 6'h30;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int SOFT_RESET_POS = 0;
  localparam int INT_CLEAR_POS = 0;
  localparam int BIAS_LSB = 4;
  localparam int SYNTH_LSB = 0;
  localparam int VTH_LSB = 0;
  localparam int VBIAS_LSB = 16;
  localparam logic [7:0] GEN1_RST = 8'h00;
  localparam logic [7:0] GEN2_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [11:0] VTH_RST = 12'h0100;
  localparam logic [11:0] VBIAS_RST = 12'h0800;

  // per-channel fault bit positions; channel 1 also holds the shutdown faults
  localparam int F_OPEN = 0;
  localparam int F_PAIR = 1;
  localparam int F_GND = 2;
  localparam int F_BAT = 3;

  // input-mode codes
  localparam logic [1:0] MODE_MIC = 2'b00;
  localparam logic [1:0] MODE_LINE = 2'b01;
  localparam logic [1:0] MODE_BOOST = 2'b10;

  typedef enum logic [2:0] {ST_OFF, ST_LOCK, ST_FRAME, ST_INIT, ST_RUN} fmrs_state_t;

endpackage

`default_nettype wire

/* hw/fmrs_sync.sv */
// two flip-flop synchroniser for a vector of unrelated pin levels
// assumes each bit is an independent level, not a multi-bit word
`default_nettype none

module fmrs_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

/* hw/fmrs_top.sv */
// fault monitor, interrupt line and power-up sequencer of a four-channel converter
// assumes an APB master on ref_clk, SAR results from logic on ref_clk, pins asynchronous
`default_nettype none

// How it works
// - seven fault kinds: open, pair short, ground, battery, bias oc, pump oc, overtemp
// - interrupt line released whenever the power-down pin is low
// - interrupt pulled low by any unmasked fault, never by a masked one
// - interrupt stays low until software writes the clear bit
// - clear bit self-clears and always reads zero
// - ordinary fault status bits are sticky until the clear bit is written
// - masks gate only the interrupt, never the status bits
// - overtemp or overcurrent drop the pump to low power and stop the converter
// - clear leaves the ordinary fault scan running; slot counter and accumulator untouched
// - scan slots: positive inputs 1-4, then negative inputs 1-4
// - scan results are ORed and applied only after slot eight
// - clear keeps any bit whose fault is still present
// - booster open detected against thresholds B and C plus or minus the window
// - internal unbalanced mode performs no diagnosis
// - power-down pin resets registers and all timing
// - serial audio output low during power-down
// - slave mode waits for all three clocks, then a frame rising edge
// - zero audio for 1041 frames after leaving power-down
// - soft reset bit zero powers down and resets timing, registers kept
// - synthesiser powered when selected and bit clock present, then lock wait
// - per-channel two-bit mode picks microphone, line, booster or unbalanced
module fmrs_top #(
  parameter int LOCK_CYCLES = fmrs_pkg::SYNTH_LOCK_CYCLES,
  parameter int CLK_LOSS_CYCLES = fmrs_pkg::CLK_LOSS_CYCLES,
  parameter int INIT_FRAMES = fmrs_pkg::INIT_FRAMES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_down_pin_n,
  input wire logic slave_mode_pin,
  input wire logic master_clock_in,
  input wire logic bit_clock,
  input wire logic frame_clock,
  input wire logic bias_oc_pin,
  input wire logic cp_oc_pin,
  input wire logic overtemp_pin,
  input wire logic sar_done,
  input wire logic [11:0] sar_code,
  input wire logic conv_data_bit,
  output logic [2:0] sar_slot,
  output logic diag_active,
  output logic int_out,
  output logic int_oe,
  output logic serial_audio_out,
  output logic adc_power_down,
  output logic cp_low_power,
  output logic synth_power_on,
  output logic [3:0] mic_bias_voltage_field,
  output logic [7:0] input_mode
);

  localparam int LOSS_W = $clog2(CLK_LOSS_CYCLES + 1);
  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);

  // ****************************************
  // pin synchronisers and clock presence
  // ****************************************
  logic [7:0] pin_s;
  logic pdn_n_s;
  logic slave_s;
  logic [2:0] clk_s;
  logic [2:0] clk_prev;
  logic [2:0] clk_ok;
  logic frame_rise;
  logic bias_oc_s;
  logic cp_oc_s;
  logic ot_s;
  logic reg_rst;

  fmrs_sync #(.WIDTH(8)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({power_down_pin_n, slave_mode_pin, master_clock_in, bit_clock, frame_clock,
        bias_oc_pin, cp_oc_pin, overtemp_pin}),
    .q(pin_s)
  );

  assign pdn_n_s = pin_s[7];
  assign slave_s = pin_s[6];
  assign clk_s = pin_s[5:3];
  assign bias_oc_s = pin_s[2];
  assign cp_oc_s = pin_s[1];
  assign ot_s = pin_s[0];
  // pin low resets everything except the synchronisers, clk_prev and prdata
  assign reg_rst = rst | ~pdn_n_s;

  // previous clock levels for edge detection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clk_prev <= 3'h0;
    end else begin
      clk_prev <= clk_s;
    end
  end

  assign frame_rise = clk_s[0] & ~clk_prev[0];

  // a clock counts as present while it toggles within the loss window
  for (genvar g = 0; g < 3; g++) begin : g_clk
    logic [LOSS_W-1:0] idle;
    always_ff @(posedge ref_clk) begin
      if (reg_rst) begin
        idle <= LOSS_W'(CLK_LOSS_CYCLES);
      end else if (clk_s[g] != clk_prev[g]) begin
        idle <= '0;
      end else if (idle != LOSS_W'(CLK_LOSS_CYCLES)) begin
        idle <= idle + 1'b1;
      end
    end
    assign clk_ok[g] = idle != LOSS_W'(CLK_LOSS_CYCLES);
  end

  // ****************************************
  // control registers
  // ****************************************
  logic [7:0] gen1;
  logic [7:0] gen2;
  logic [15:0] mask_all;
  logic [3:0] int_set_hi;
  logic [11:0] thb;
  logic [11:0] thc;
  logic [11:0] vth;
  logic [11:0] vbias;
  logic soft_reset_bit;
  logic [1:0] clock_synth_select;
  logic [5:0] idx;
  logic wr;
  logic mapped;
  logic clear_pulse;

  assign idx = paddr[7:2];
  assign wr = psel & penable & pwrite;
  assign soft_reset_bit = gen1[fmrs_pkg::SOFT_RESET_POS];
  assign clock_synth_select = gen2[fmrs_pkg::SYNTH_LSB +: 2];
  assign mic_bias_voltage_field = gen2[fmrs_pkg::BIAS_LSB +: 4];
  // a write of one is a single-cycle command, never stored
  assign clear_pulse = wr & (idx == fmrs_pkg::IDX_INTSET) & pwdata[fmrs_pkg::INT_CLEAR_POS];

  // address decode
  always_comb begin
    mapped = 1'b0;
    if (idx <= fmrs_pkg::IDX_MODE || (idx >= fmrs_pkg::IDX_SUMMARY && idx <= fmrs_pkg::IDX_MASK4) ||
        idx == fmrs_pkg::IDX_INTSET || (idx >= fmrs_pkg::IDX_THB_HI && idx <= fmrs_pkg::IDX_THC_LO) ||
        idx == fmrs_pkg::IDX_DIAG) begin
      mapped = 1'b1;
    end
  end

  // register writes; reset by the power-down pin, kept by soft reset
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      gen1 <= fmrs_pkg::GEN1_RST;
      gen2 <= fmrs_pkg::GEN2_RST;
      input_mode <= fmrs_pkg::MODE_RST;
      mask_all <= 16'h0000;
      int_set_hi <= 4'h0;
      thb <= 12'h000;
      thc <= 12'h000;
      vth <= fmrs_pkg::VTH_RST;
      vbias <= fmrs_pkg::VBIAS_RST;
    end else if (wr) begin
      case (idx)
        fmrs_pkg::IDX_GEN1: gen1 <= pwdata[7:0];
        fmrs_pkg::IDX_GEN2: gen2 <= pwdata[7:0];
        fmrs_pkg::IDX_MODE: input_mode <= pwdata[7:0];
        fmrs_pkg::IDX_INTSET: int_set_hi <= pwdata[7:4];
        fmrs_pkg::IDX_THB_HI: thb[11:4] <= pwdata[7:0];
        fmrs_pkg::IDX_THB_LO: thb[3:0] <= pwdata[7:4];
        fmrs_pkg::IDX_THC_HI: thc[11:4] <= pwdata[7:0];
        fmrs_pkg::IDX_THC_LO: thc[3:0] <= pwdata[7:4];
        fmrs_pkg::IDX_DIAG: begin
          vth <= pwdata[fmrs_pkg::VTH_LSB +: 12];
          vbias <= pwdata[fmrs_pkg::VBIAS_LSB +: 12];
        end
        default: begin
          if (idx >= fmrs_pkg::IDX_MASK1 && idx <= fmrs_pkg::IDX_MASK4) begin
            mask_all[{idx[1:0], 2'b00} +: 4] <= pwdata[3:0];
          end
        end
      endcase
    end
  end

  // ****************************************
  // power-up sequencer
  // ****************************************
  fmrs_pkg::fmrs_state_t state;
  fmrs_pkg::fmrs_state_t next_state;
  logic [LOCK_W-1:0] lock_cnt;
  logic locked;
  logic [10:0] frame_cnt;
  logic clocks_ok;

  // slave mode needs master, bit and frame clock; master mode only the master clock
  assign clocks_ok = slave_s ? (&clk_ok) : clk_ok[2];
  assign synth_power_on = soft_reset_bit & (clock_synth_select != 2'b00) & clk_ok[1];
  assign locked = lock_cnt == LOCK_W'(LOCK_CYCLES);

  // lock timer runs while the synthesiser is powered
  always_ff @(posedge ref_clk) begin
    if (reg_rst || !synth_power_on) begin
      lock_cnt <= '0;
    end else if (!locked) begin
      lock_cnt <= lock_cnt + 1'b1;
    end
  end

  // next state
  always_comb begin
    next_state = state;
    case (state)
      fmrs_pkg::ST_OFF: begin
        if (soft_reset_bit && clocks_ok) begin
          next_state = fmrs_pkg::ST_LOCK;
        end
      end
      fmrs_pkg::ST_LOCK: begin
        if (clock_synth_select == 2'b00 || locked) begin
          next_state = fmrs_pkg::ST_FRAME;
        end
      end
      fmrs_pkg::ST_FRAME: begin
        if (frame_rise) begin
          next_state = fmrs_pkg::ST_INIT;
        end
      end
      fmrs_pkg::ST_INIT: begin
        if (frame_rise && frame_cnt == 11'(INIT_FRAMES - 1)) begin
          next_state = fmrs_pkg::ST_RUN;
        end
      end
      fmrs_pkg::ST_RUN: next_state = fmrs_pkg::ST_RUN;
      default: next_state = fmrs_pkg::ST_OFF;
    endcase
    if (!soft_reset_bit || !clocks_ok) begin
      next_state = fmrs_pkg::ST_OFF;
    end
  end

  // state register and frame counter
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      state <= fmrs_pkg::ST_OFF;
      frame_cnt <= 11'h000;
    end else begin
      state <= next_state;
      if (state != fmrs_pkg::ST_INIT) begin
        frame_cnt <= 11'h000;
      end else if (frame_rise) begin
        frame_cnt <= frame_cnt + 1'b1;
      end
    end
  end

  // ****************************************
  // shutdown faults
  // ****************************************
  logic [2:0] stop_flags; // overtemp, pump overcurrent, bias overcurrent
  logic overtemperature_flag;
  logic charge_pump_overcurrent_flag;
  logic bias_overcurrent_flag;

  // only a restart clears these, the clear bit does not
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      stop_flags <= 3'h0;
    end else if (!soft_reset_bit) begin
      stop_flags <= {ot_s, cp_oc_s, bias_oc_s};
    end else begin
      stop_flags <= stop_flags | {ot_s, cp_oc_s, bias_oc_s};
    end
  end

  assign overtemperature_flag = stop_flags[2];
  assign charge_pump_overcurrent_flag = stop_flags[1];
  assign bias_overcurrent_flag = stop_flags[0];
  assign cp_low_power = |stop_flags;
  assign adc_power_down = (state != fmrs_pkg::ST_INIT && state != fmrs_pkg::ST_RUN) | (|stop_flags);
  assign diag_active = soft_reset_bit & ~charge_pump_overcurrent_flag;

  // audio output held low until the converter is initialised
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      serial_audio_out <= 1'b0;
    end else begin
      serial_audio_out <= (state == fmrs_pkg::ST_RUN) & ~adc_power_down & conv_data_bit;
    end
  end

  // ****************************************
  // channel scan and fault evaluation
  // ****************************************
  logic [1:0] ch;
  logic neg;
  logic [1:0] mode;
  logic [11:0] pos_meas [4];
  logic [3:0] hit;
  logic [15:0] hit_vec;
  logic [15:0] acc;
  logic [15:0] scan_res;
  logic [15:0] last_res;
  logic [15:0] mon;
  logic commit;
  logic [12:0] hi_lim;
  logic [12:0] diff;

  // code lies within centre plus or minus the window
  function automatic logic in_window(input logic [11:0] code, input logic [11:0] centre,
                                     input logic [11:0] win);
    logic [12:0] lo;
    logic [12:0] hi;
    lo = (centre > win) ? {1'b0, centre - win} : 13'h0000;
    hi = {1'b0, centre} + {1'b0, win};
    return ({1'b0, code} >= lo) && ({1'b0, code} <= hi);
  endfunction

  assign ch = sar_slot[1:0];
  assign neg = sar_slot[2];
  assign mode = input_mode[{ch, 1'b0} +: 2];
  assign hi_lim = {1'b0, vbias} + {1'b0, vth};
  assign diff = (pos_meas[ch] > sar_code) ? {1'b0, pos_meas[ch] - sar_code} : {1'b0, sar_code - pos_meas[ch]};

  // fault criteria picked per input mode
  always_comb begin
    hit = 4'h0;
    case (mode)
      fmrs_pkg::MODE_MIC, fmrs_pkg::MODE_LINE: begin
        hit[fmrs_pkg::F_BAT] = {1'b0, sar_code} >= hi_lim;
        hit[fmrs_pkg::F_GND] = sar_code <= vth;
        hit[fmrs_pkg::F_PAIR] = neg & (diff <= {1'b0, vth});
        hit[fmrs_pkg::F_OPEN] = neg ? (sar_code <= vth) : in_window(sar_code, vbias, vth);
      end
      fmrs_pkg::MODE_BOOST: begin
        hit[fmrs_pkg::F_OPEN] = in_window(sar_code, neg ? thc : thb, vth);
      end
      default: hit = 4'h0;
    endcase
  end

  assign hit_vec = 16'(hit) << {ch, 2'b00};
  assign commit = diag_active & sar_done & (sar_slot == 3'h7);
  assign scan_res = acc | hit_vec;

  // slot counter and accumulator; cleared when detection stops
  always_ff @(posedge ref_clk) begin
    if (reg_rst || !diag_active) begin
      sar_slot <= 3'h0;
      acc <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        pos_meas[i] <= 12'h000;
      end
    end else if (sar_done) begin
      sar_slot <= sar_slot + 1'b1;
      acc <= commit ? 16'h0000 : scan_res;
      if (!neg) begin
        pos_meas[ch] <= sar_code;
      end
    end
  end

  // sticky status; a clear keeps what the last scan still saw
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      mon <= 16'h0000;
      last_res <= 16'h0000;
    end else begin
      if (commit) begin
        last_res <= scan_res;
      end
      if (clear_pulse) begin
        mon <= last_res | (commit ? scan_res : 16'h0000);
      end else if (commit) begin
        mon <= mon | scan_res;
      end
    end
  end

  // ****************************************
  // interrupt line
  // ****************************************
  logic int_latched;
  logic int_set;

  assign int_set = (commit & (|(scan_res & ~mask_all))) | (|stop_flags);

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      int_latched <= 1'b0;
    end else begin
      int_latched <= int_set | (int_latched & ~clear_pulse);
    end
  end

  assign int_out = 1'b0;
  assign int_oe = int_latched & pdn_n_s;

  // ****************************************
  // APB read path
  // ****************************************
  logic [7:0] rd;

  // read mux
  always_comb begin
    rd = 8'h00;
    case (idx)
      fmrs_pkg::IDX_GEN1: rd = gen1;
      fmrs_pkg::IDX_GEN2: rd = gen2;
      fmrs_pkg::IDX_MODE: rd = input_mode;
      fmrs_pkg::IDX_SUMMARY: begin
        rd = {4'h0, |mon[15:12], |mon[11:8], |mon[7:4], (|mon[3:0]) | (|stop_flags)};
      end
      fmrs_pkg::IDX_MON1: rd = {1'b0, overtemperature_flag, charge_pump_overcurrent_flag,
                                bias_overcurrent_flag, mon[3:0]};
      fmrs_pkg::IDX_INTSET: rd = {int_set_hi, 4'h0};
      fmrs_pkg::IDX_THB_HI: rd = thb[11:4];
      fmrs_pkg::IDX_THB_LO: rd = {thb[3:0], 4'h0};
      fmrs_pkg::IDX_THC_HI: rd = thc[11:4];
      fmrs_pkg::IDX_THC_LO: rd = {thc[3:0], 4'h0};
      default: begin
        if (idx > fmrs_pkg::IDX_MON1 && idx <= fmrs_pkg::IDX_MON4) begin
          rd = {4'h0, mon[{idx[1:0], 2'b00} +: 4]};
        end else if (idx >= fmrs_pkg::IDX_MASK1 && idx <= fmrs_pkg::IDX_MASK4) begin
          rd = {4'h0, mask_all[{idx[1:0], 2'b00} +: 4]};
        end
      end
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= (idx == fmrs_pkg::IDX_DIAG) ? {4'h0, vbias, 4'h0, vth} : {24'h00_0000, rd};
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

endmodule

`default_nettype wire

/* verification/fmrs_monitor.sv */
// checker for the fault monitor and reset sequencer, ports of fmrs_top only
// assumes one ref_clk domain with synchronous active-high rst
`default_nettype none

module fmrs_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_down_pin_n,
  input wire logic bias_oc_pin,
  input wire logic cp_oc_pin,
  input wire logic overtemp_pin,
  input wire logic sar_done,
  input wire logic [2:0] sar_slot,
  input wire logic diag_active,
  input wire logic int_out,
  input wire logic int_oe,
  input wire logic serial_audio_out,
  input wire logic adc_power_down,
  input wire logic cp_low_power
);
  // ****************************************
  // helpers and properties
  // ****************************************
  logic [3:0] since_evt;
  wire wr_ctl = psel && penable && pwrite && (paddr[7:2] == 6'h00 || paddr[7:2] == 6'h14);
  wire end7 = sar_done && diag_active && sar_slot == 3'd7;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // cycles since a scan end or a shutdown fault report
  always_ff @(posedge ref_clk) begin
    if (rst || end7 || bias_oc_pin || cp_oc_pin || overtemp_pin) since_evt <= 4'h0;
    else if (since_evt != 4'hf) since_evt <= since_evt + 4'h1;
  end

  a_apb_ready: assert property (psel && penable |-> pready) else $error("pready low in access phase");
  a_err_unmapped: assert property (psel && penable && paddr[7:2] == 6'h03 |-> pslverr)
    else $error("no error on unmapped index");
  a_clear_zero: assert property (psel && !penable && !pwrite && paddr[7:2] == 6'h14 |=> prdata[0] == 1'b0)
    else $error("clear bit read back as one");
  a_int_od: assert property (int_oe |-> int_out == 1'b0)
    else $error("interrupt driven high");
  a_pdn_release: assert property (!power_down_pin_n [*3] |-> !int_oe)
    else $error("interrupt driven in power-down");
  a_audio_pdn: assert property (!power_down_pin_n [*4] |-> !serial_audio_out)
    else $error("audio output high in power-down");
  a_int_hold: assert property (power_down_pin_n [*3] ##0 (int_oe && !wr_ctl) |=> int_oe)
    else $error("interrupt released without clear");
  a_slot_step: assert property (sar_done && diag_active && !wr_ctl |=> sar_slot == $past(sar_slot) + 3'd1)
    else $error("scan slot did not advance by one");
  a_scan_gate: assert property ($rose(int_oe) |-> since_evt <= 4'h5)
    else $error("interrupt raised outside scan end");
  a_pump_stop: assert property (cp_oc_pin [*4] |-> !diag_active && adc_power_down)
    else $error("pump overcurrent left diagnosis running");
  a_temp_stop: assert property (overtemp_pin [*4] |-> adc_power_down && cp_low_power)
    else $error("overtemperature left converter powered");
endmodule

bind fmrs_top fmrs_monitor u_fmrs_monitor (.*);

`default_nettype wire

/* verification/fmrs_host_model.sv */
// host side of the interrupt line: open-drain wire with a pull-up resistor
// assumes the device pulls low only while int_oe is high
`default_nettype none

module fmrs_host_model (
  input wire logic int_oe,
  input wire logic int_out,
  output logic int_line
);
  // ****************************************
  // line resolution
  // ****************************************
  // released line rises to the pull-up level
  assign int_line = int_oe ? int_out : 1'b1;
endmodule

`default_nettype wire

/* verification/fmrs_tb_top.sv */
// testbench: APB register sequences, sar scans and pin events against fmrs_top
// assumes fmrs_pkg is compiled first; lock, loss and init counts are shortened
`default_nettype none

module fmrs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals, design and host
  // ****************************************
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, power_down_pin_n, slave_mode_pin;
  logic bias_oc_pin, cp_oc_pin, overtemp_pin, sar_done, conv_data_bit, diag_active, int_out, int_oe;
  logic serial_audio_out, adc_power_down, cp_low_power, synth_power_on, int_line, slv, pre7;
  logic master_clock_in, bit_clock, frame_clock;
  logic [7:0] paddr, input_mode;
  logic [31:0] pwdata, prdata, rdv;
  logic [11:0] sar_code;
  logic [2:0] sar_slot;
  logic [3:0] mic_bias_voltage_field;
  logic [4:0] div;
  int n_fail, cmp_count, n;

  fmrs_top #(.LOCK_CYCLES(20), .CLK_LOSS_CYCLES(64), .INIT_FRAMES(4)) DUT (.*);
  fmrs_host_model u_host (.int_oe(int_oe), .int_out(int_out), .int_line(int_line));

  // reference clock and divided converter clocks
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) div <= div + 5'h1;
  assign master_clock_in = div[0];
  assign bit_clock = div[1];
  assign frame_clock = div[4];

  // ****************************************
  // tasks
  // ****************************************
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      n_fail++;
      tally_and_finish;
    end
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, idx, 32'h0);
    chk(what, rdv, exp);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // eight slots, clean codes except channel 2 and channel 4 positive
  task automatic scan(input logic [11:0] c2, input logic [11:0] c4);
    for (int s = 0; s < 8; s++) begin
      @(negedge ref_clk);
      chk("slot", {29'h0, sar_slot}, s);
      if (s == 7) pre7 = int_oe;
      @(posedge ref_clk);
      sar_code <= (s == 1) ? c2 : (s == 3) ? c4 : (s < 4) ? 12'h400 : 12'h600;
      sar_done <= 1'b1;
      @(posedge ref_clk);
      sar_done <= 1'b0;
    end
    tick(3);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst, psel, penable, pwrite, bias_oc_pin, cp_oc_pin, overtemp_pin, sar_done} = 8'hff;
    {psel, penable, pwrite, bias_oc_pin, cp_oc_pin, overtemp_pin, sar_done} = 7'h0;
    {power_down_pin_n, slave_mode_pin, conv_data_bit} = 3'h7;
    paddr = 8'h0;
    pwdata = 32'h0;
    sar_code = 12'h0;
    div = 5'h0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    tick(3);
    rd(fmrs_pkg::IDX_GEN1, 32'h0, "gen1");
    rd(fmrs_pkg::IDX_DIAG, 32'h0800_0100, "window");
    rd(6'h03, 32'h0, "unmapped");
    chk("slverr", slv, 1'b1);
    apb(1'b1, fmrs_pkg::IDX_GEN2, 32'h50);
    apb(1'b1, fmrs_pkg::IDX_GEN1, 32'h1);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, fmrs_pkg::IDX_GEN2, 32'h50 | s);
      tick(4);
      chk("synth", synth_power_on, s != 0);
    end
    tick(40);
    chk("audio_init", serial_audio_out, 1'b0);
    for (n = 0; n < 3000 && serial_audio_out !== 1'b1; n++) tick(1);
    chk("audio_run", serial_audio_out, 1'b1);
    apb(1'b1, fmrs_pkg::IDX_MODE, 32'hc0);
    scan(12'h050, 12'h050);
    chk("pre7", pre7, 1'b0);
    chk("modes", input_mode, 8'hc0);
    chk("int_set", int_line, 1'b0);
    rd(fmrs_pkg::IDX_MON1 + 6'h1, 32'h4, "mon2");
    rd(fmrs_pkg::IDX_MON4, 32'h0, "mon4");
    rd(fmrs_pkg::IDX_SUMMARY, 32'h2, "summary");
    scan(12'h400, 12'h400);
    chk("int_hold", int_line, 1'b0);
    rd(fmrs_pkg::IDX_MON1 + 6'h1, 32'h4, "mon2_sticky");
    apb(1'b1, fmrs_pkg::IDX_INTSET, 32'h1);
    rd(fmrs_pkg::IDX_INTSET, 32'h0, "clear_bit");
    rd(fmrs_pkg::IDX_MON1 + 6'h1, 32'h0, "mon2_clr");
    chk("int_clr", int_line, 1'b1);
    scan(12'h050, 12'h400);
    apb(1'b1, fmrs_pkg::IDX_INTSET, 32'h1);
    rd(fmrs_pkg::IDX_MON1 + 6'h1, 32'h4, "mon2_persist");
    apb(1'b1, fmrs_pkg::IDX_MASK1 + 6'h1, 32'h4);
    scan(12'h400, 12'h400);
    apb(1'b1, fmrs_pkg::IDX_INTSET, 32'h1);
    scan(12'h050, 12'h400);
    chk("int_masked", int_line, 1'b1);
    rd(fmrs_pkg::IDX_MON1 + 6'h1, 32'h4, "mon2_masked");
    @(posedge ref_clk) overtemp_pin <= 1'b1;
    tick(5);
    chk("temp_adc", adc_power_down, 1'b1);
    chk("temp_pump", cp_low_power, 1'b1);
    chk("temp_int", int_line, 1'b0);
    apb(1'b0, fmrs_pkg::IDX_MON1, 32'h0);
    chk("mon1_temp", rdv & 32'h70, 32'h40);
    @(posedge ref_clk) overtemp_pin <= 1'b0;
    apb(1'b1, fmrs_pkg::IDX_INTSET, 32'h1);
    tick(3);
    chk("temp_stuck", int_line, 1'b0);
    @(posedge ref_clk) power_down_pin_n <= 1'b0;
    tick(5);
    chk("pdn_int", int_line, 1'b1);
    chk("pdn_audio", serial_audio_out, 1'b0);
    @(posedge ref_clk) power_down_pin_n <= 1'b1;
    tick(3);
    rd(fmrs_pkg::IDX_MASK1 + 6'h1, 32'h0, "mask2_dflt");
    apb(1'b1, fmrs_pkg::IDX_GEN2, 32'h50);
    apb(1'b1, fmrs_pkg::IDX_GEN1, 32'h1);
    @(posedge ref_clk) cp_oc_pin <= 1'b1;
    tick(5);
    chk("pump_diag", diag_active, 1'b0);
    @(posedge ref_clk) cp_oc_pin <= 1'b0;
    apb(1'b1, fmrs_pkg::IDX_GEN1, 32'h0);
    tick(3);
    chk("srst_adc", adc_power_down, 1'b1);
    chk("srst_int", int_line, 1'b0);
    chk("srst_bias", mic_bias_voltage_field, 4'h5);
    rd(fmrs_pkg::IDX_GEN2, 32'h50, "gen2_kept");
    apb(1'b1, fmrs_pkg::IDX_INTSET, 32'h1);
    tick(1);
    chk("srst_clr", int_line, 1'b1);
    apb(1'b1, fmrs_pkg::IDX_GEN1, 32'h1);
    apb(1'b1, fmrs_pkg::IDX_MODE, 32'h20);
    apb(1'b1, fmrs_pkg::IDX_THB_HI, 32'h40);
    scan(12'h400, 12'h400);
    rd(fmrs_pkg::IDX_MON1 + 6'h2, 32'h1, "mon3_boost");
    tally_and_finish;
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_fail++;
    tally_and_finish;
  end
endmodule

`default_nettype wire
